/* File: core/nsq_pkg.sv */
package nsq_pkg;
	localparam int CLK_MHZ    = 100;
	localparam int T_PHASE_NS = 25;
	localparam int PHASE_CYC  = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_WB_NS    = 100;
	localparam int WB_CYC     = (T_WB_NS * CLK_MHZ + 999) / 1000;

	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STAT = 12'h004;
	localparam logic [11:0] REG_CFG  = 12'h008;

	localparam int CTRL_BYTE_LSB = 0;
	localparam int CTRL_KIND_LSB = 8;
	localparam int STAT_BUSY     = 0;
	localparam int STAT_GUARD    = 1;
	localparam int STAT_REFUSED  = 2;
	localparam int STAT_RB       = 3;
	localparam int STAT_RD_LSB   = 8;
	localparam int CFG_WP_EN     = 0;
	localparam int CFG_CE_KEEP   = 1;
	localparam logic [1:0] CFG_RST = 2'h0;

	localparam logic [7:0] CMD_PROG_LOAD  = 8'h80;
	localparam logic [7:0] CMD_RAND_IN    = 8'h85;
	localparam logic [7:0] CMD_PROG_CONF  = 8'h10;
	localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_RESET      = 8'hFF;
	localparam logic [7:0] CMD_ID         = 8'h90;
	localparam logic [7:0] CMD_ERASE_CONF = 8'hD0;

	typedef enum logic [1:0] {
		K_CMD  = 2'b00,
		K_ADDR = 2'b01,
		K_DIN  = 2'b10,
		K_DOUT = 2'b11
	} nsq_kind_e;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_LEAD = 2'b01,
		S_HIGH = 2'b10,
		S_TAIL = 2'b11
	} nsq_state_e;

	typedef struct packed {
		nsq_kind_e  kind;
		logic [7:0] data;
	} nsq_req_s;

	typedef struct packed {
		logic       ce_n;
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       re_n;
		logic       wp_n;
		logic       io_oe;
		logic [7:0] io_out;
	} nsq_pins_s;

	function automatic logic starts_busy(input logic [7:0] c);
		return c == CMD_PROG_CONF || c == CMD_CACHE_PROG || c == CMD_ERASE_CONF || c == CMD_RESET;
	endfunction

	function automatic logic busy_allowed(input nsq_req_s r);
		return r.kind == K_DOUT || (r.kind == K_CMD && (r.data == CMD_STATUS || r.data == CMD_RESET));
	endfunction
endpackage

/* File: core/nsq_host_ctrl.sv */
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - program load 80h, address, then page data
// - 85h plus new column redirects data loading
// - confirm 10h starts internal page program
// - at most four partial programs per page
// - cache program ends sequence with 15h
// - next cache sequence only when cache ready
// - ready-pin-only hosts finish with 10h
// - erase done on pin; check bit zero
// - ID 90h, address 00h, five bytes
module nsq_host_ctrl
	import nsq_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        rb_n_in,
	input  wire logic [7:0]  io_in,
	output nsq_pins_s        pins_out
);
	logic             rb_s1_ff;
	logic             rb_s2_ff;
	logic [7:0]       io_s1_ff;
	logic [7:0]       io_s2_ff;
	logic             pready_ff;
	logic             pslverr_ff;
	logic [31:0]      prdata_ff;
	logic [1:0]       cfg_ff;
	logic             refused_ff;
	logic             guard_ff;
	logic [7:0]       wb_cnt_ff;
	logic [7:0]       rd_byte_ff;
	logic [7:0]       div_ff;
	nsq_state_e       state_ff;
	nsq_state_e       nxt_state;
	nsq_req_s         req_ff;
	nsq_req_s         wr_req;
	nsq_req_s         cur_req;
	nsq_pins_s        pins_ff;
	nsq_pins_s        nxt_pins;
	logic             take;
	logic             ctrl_wr;
	logic             refuse;
	logic             start;
	logic             tick;
	logic             mapped;
	logic             arm;

	// pin inputs come from the device's own timing, so two flops first
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rb_s1_ff <= 1'b0;
			rb_s2_ff <= 1'b0;
			io_s1_ff <= 8'h00;
			io_s2_ff <= 8'h00;
		end else begin
			rb_s1_ff <= rb_n_in;
			rb_s2_ff <= rb_s1_ff;
			io_s1_ff <= io_in;
			io_s2_ff <= io_s1_ff;
		end
	end

	assign take    = psel_in & penable_in & pready_ff;
	assign mapped  = paddr_in == REG_CTRL || paddr_in == REG_STAT || paddr_in == REG_CFG;
	assign wr_req  = '{kind: nsq_kind_e'(pwdata_in[CTRL_KIND_LSB +: 2]), data: pwdata_in[CTRL_BYTE_LSB +: 8]};
	assign ctrl_wr = take & pwrite_in & (paddr_in == REG_CTRL);
	// a second order while a cycle runs is refused, not queued
	assign refuse  = ctrl_wr & ((state_ff != S_IDLE) | (guard_ff & ~busy_allowed(wr_req)));
	assign start   = ctrl_wr & ~refuse;
	assign tick    = div_ff == 8'(PHASE_CYC - 1);
	// order taken at this edge drives the pins at once; a stale kind would strobe
	assign cur_req = start ? wr_req : req_ff;
	assign arm     = state_ff == S_TAIL && tick && req_ff.kind == K_CMD && starts_busy(req_ff.data);

	// apb: one wait-free access, answer built in the setup cycle
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= psel_in & ~penable_in;
			pslverr_ff <= psel_in & ~penable_in & ~mapped;
			prdata_ff  <= 32'h0000_0000;
			if (psel_in && !penable_in && !pwrite_in) begin
				if (paddr_in == REG_STAT) begin
					prdata_ff[STAT_BUSY]            <= state_ff != S_IDLE;
					prdata_ff[STAT_GUARD]           <= guard_ff;
					prdata_ff[STAT_REFUSED]         <= refused_ff;
					prdata_ff[STAT_RB]              <= rb_s2_ff;
					prdata_ff[STAT_RD_LSB +: 8]     <= rd_byte_ff;
				end else if (paddr_in == REG_CFG) begin
					prdata_ff[1:0] <= cfg_ff;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg_ff <= CFG_RST;
		end else if (take && pwrite_in && paddr_in == REG_CFG) begin
			cfg_ff <= pwdata_in[1:0];
		end
	end

	// sticky refusal, write one to clear; a new refusal wins
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			refused_ff <= 1'b0;
		end else if (refuse) begin
			refused_ff <= 1'b1;
		end else if (take && pwrite_in && paddr_in == REG_STAT && pwdata_in[STAT_REFUSED]) begin
			refused_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			req_ff <= '{kind: K_CMD, data: 8'h00};
		end else if (start) begin
			req_ff <= wr_req;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_ff <= 8'h00;
		end else if (start || tick) begin
			div_ff <= 8'h00;
		end else if (state_ff != S_IDLE) begin
			div_ff <= div_ff + 8'h01;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (start) begin
					nxt_state = S_LEAD;
				end
			end
			S_LEAD: begin
				if (tick) begin
					nxt_state = S_HIGH;
				end
			end
			S_HIGH: begin
				if (tick) begin
					nxt_state = S_TAIL;
				end
			end
			S_TAIL: begin
				if (tick) begin
					nxt_state = S_IDLE;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_ff <= S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// pins follow the next state so they leave flops in step with it
	always_comb begin
		nxt_pins        = '0;
		nxt_pins.ce_n   = ~cfg_ff[CFG_CE_KEEP] & (nxt_state == S_IDLE);
		nxt_pins.we_n   = 1'b1;
		nxt_pins.re_n   = 1'b1;
		nxt_pins.wp_n   = cfg_ff[CFG_WP_EN];
		nxt_pins.io_out = cur_req.data;
		if (nxt_state != S_IDLE) begin
			nxt_pins.io_oe = cur_req.kind != K_DOUT && nxt_state != S_TAIL;
			nxt_pins.cle   = cur_req.kind == K_CMD && nxt_state != S_TAIL;
			nxt_pins.ale   = cur_req.kind == K_ADDR && nxt_state != S_TAIL;
			nxt_pins.we_n  = ~(nxt_state == S_LEAD && cur_req.kind != K_DOUT);
			nxt_pins.re_n  = ~(nxt_state == S_LEAD && cur_req.kind == K_DOUT);
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pins_ff <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
				wp_n: 1'b0, io_oe: 1'b0, io_out: 8'h00};
		end else begin
			pins_ff <= nxt_pins;
		end
	end

	// read byte taken as the read strobe rises; status and id bytes alike
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_byte_ff <= 8'h00;
		end else if (state_ff == S_LEAD && tick && req_ff.kind == K_DOUT) begin
			rd_byte_ff <= io_s2_ff;
		end
	end

	// busy guard armed after confirm or reset; tWB passes before ready counts
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			guard_ff  <= 1'b0;
			wb_cnt_ff <= 8'h00;
		end else if (arm) begin
			// reset arms it too, so the next order waits out tWB again
			guard_ff  <= 1'b1;
			wb_cnt_ff <= 8'(WB_CYC);
		end else if (guard_ff && wb_cnt_ff != 8'h00) begin
			wb_cnt_ff <= wb_cnt_ff - 8'h01;
		end else if (guard_ff && rb_s2_ff) begin
			guard_ff <= 1'b0;
		end
	end

	assign prdata_out  = prdata_ff;
	assign pready_out  = pready_ff;
	assign pslverr_out = pslverr_ff;
	assign pins_out    = pins_ff;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence seq_lead;
		state_ff == S_LEAD [*3];
	endsequence
	sequence seq_high;
		state_ff == S_HIGH [*3];
	endsequence

	AST_CYCLE_SHAPE: assert property (start |=> seq_lead ##1 seq_high ##1 state_ff == S_TAIL)
		else $error("cycle phases wrong");
	AST_CMD_LATCH: assert property ($rose(pins_ff.we_n) && pins_ff.cle |-> !pins_ff.ale && pins_ff.io_oe)
		else $error("command strobe without clean latch lines");
	AST_DATA_STABLE: assert property ($rose(pins_ff.we_n) |-> $stable(pins_ff.io_out) && pins_ff.io_oe)
		else $error("data moved at write strobe rise");
	AST_GUARD_BLOCK: assert property (guard_ff && ctrl_wr && !busy_allowed(wr_req) |=> $stable(req_ff) && refused_ff)
		else $error("order accepted while busy");
	AST_GUARD_SET: assert property (state_ff == S_TAIL && tick && req_ff.kind == K_CMD
		&& req_ff.data == CMD_PROG_CONF |=> guard_ff)
		else $error("guard not armed by confirm");
	AST_WB_HOLD: assert property ($rose(guard_ff) |-> guard_ff [*8])
		else $error("guard dropped before tWB");
	AST_GUARD_CLR: assert property (guard_ff && !arm && wb_cnt_ff == 8'h00 && rb_s2_ff |=> !guard_ff)
		else $error("guard kept after ready");
	AST_READ_CAPT: assert property (state_ff == S_LEAD && tick && req_ff.kind == K_DOUT
		|=> rd_byte_ff == $past(io_s2_ff) && pins_ff.re_n)
		else $error("read byte not captured");
	AST_WP_PIN: assert property (##1 pins_ff.wp_n == $past(cfg_ff[CFG_WP_EN]))
		else $error("write protect pin off config");

	AST_BUSY_REFUSE: assert property (ctrl_wr && state_ff != S_IDLE |=> refused_ff && $stable(req_ff))
		else $error("order taken while a cycle runs");
	AST_REFUSE_SET: assert property (refuse |=> refused_ff)
		else $error("refusal not recorded");
	AST_ADDR_LATCH: assert property ($rose(pins_ff.we_n) && pins_ff.ale |-> !pins_ff.cle && pins_ff.io_oe)
		else $error("address strobe without clean latch lines");
	AST_LATCH_EXCL: assert property (!(pins_ff.cle && pins_ff.ale))
		else $error("command and address latch both high");
	AST_CE_HELD: assert property (state_ff != S_IDLE |-> !pins_ff.ce_n)
		else $error("chip enable high inside a cycle");
	AST_TAIL_RELEASE: assert property (state_ff == S_TAIL
		|-> !pins_ff.cle && !pins_ff.ale && !pins_ff.io_oe)
		else $error("latch lines held into tail");
	AST_READ_STROBE: assert property (state_ff == S_LEAD && req_ff.kind == K_DOUT
		|-> !pins_ff.re_n && !pins_ff.io_oe)
		else $error("read strobe or drive wrong in read cycle");
	AST_NO_CONTEND: assert property (pins_ff.io_oe |-> pins_ff.re_n)
		else $error("host drives while device reads out");
endmodule

/* File: test/nsq_nand_model.sv */
`timescale 1ns/1ps
module nsq_nand_model
	import nsq_pkg::*;
#(
	parameter logic [7:0] MAKER  = 8'hA5,
	parameter logic [7:0] DEVICE = 8'h3C,
	parameter int         BUSY   = 200
)(
	input  wire logic      clk_in,
	input  wire nsq_pins_s pins_in,
	input  wire logic      fail_in,
	output logic           rb_low_out,
	output logic [7:0]     io_out
);
	// maker and device codes are arbitrary values
	logic [7:0] cmd  = 0;
	logic [7:0] sel  = 0;
	logic [7:0] last = 0;
	logic       pf   = 0;
	logic       prev = 0;
	logic       res  = 0;
	int         busy = 0;
	int         idx  = 0;
	function automatic logic [7:0] rd_byte(input int i);
		logic [39:0] v;
		v = (sel == 8'h20) ? {32'h4F4E_4649, 8'h00} : {MAKER, DEVICE, 8'h90, 8'h95, 8'h07};
		if (cmd == CMD_STATUS) begin
			return {pins_in.wp_n, {2{busy == 0}}, 3'b000, prev, pf};
		end
		return 8'(v >> (8 * (4 - i)));
	endfunction
	always @(posedge pins_in.we_n) begin
		if (!pins_in.ce_n && pins_in.cle && (busy == 0 || pins_in.io_out inside {CMD_STATUS, CMD_RESET})) begin
			cmd = pins_in.io_out;
			idx = 0;
			if (cmd inside {CMD_PROG_CONF, CMD_CACHE_PROG, CMD_ERASE_CONF, CMD_RESET} && pins_in.wp_n) begin
				busy = (cmd == CMD_RESET) ? 3 : BUSY;
				res = fail_in && cmd != CMD_RESET;
			end
		end
		if (!pins_in.ce_n && pins_in.ale && cmd == CMD_ID) begin
			sel = pins_in.io_out;
		end
	end
	// busy runs on its own, chip enable plays no part; falling edge keeps rb off the sampling edge
	always @(negedge clk_in) begin
		if (busy == 1) begin
			pf = res;
			prev = res;
		end
		if (busy > 0) begin
			busy = busy - 1;
		end
	end
	always @(negedge pins_in.re_n) last = rd_byte(idx);
	always @(posedge pins_in.re_n) idx = idx + 1;
	assign rb_low_out = busy != 0;
	// released bus shows the inverse so a stale byte cannot pass
	assign io_out = (!pins_in.ce_n && !pins_in.re_n) ? last : ~last;
endmodule

/* File: test/test_nsq_host_ctrl.sv */
`timescale 1ns/1ps
module test_nsq_host_ctrl;
	import nsq_pkg::*;
	localparam logic [7:0] MAKER  = 8'hA5; // arbitrary
	localparam logic [7:0] DEVICE = 8'h3C; // arbitrary
	logic        sys_clk_in = 0;
	logic        nrst_in    = 0;
	logic        psel       = 0;
	logic        penable    = 0;
	logic        pwrite     = 0;
	logic [11:0] paddr      = 0;
	logic [31:0] pwdata     = 0;
	logic [31:0] prdata;
	logic [31:0] r;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        rb_low;
	logic        fail       = 0;
	logic        fb;
	logic [7:0]  dev_io;
	logic [7:0]  io;
	nsq_pins_s   pins;
	int          failures   = 0;
	int          checks     = 0;
	logic [7:0]  conf [3]   = '{CMD_PROG_CONF, CMD_CACHE_PROG, CMD_ERASE_CONF};
	always #5 sys_clk_in = ~sys_clk_in;
	assign io = pins.io_oe ? pins.io_out : dev_io;
	nsq_host_ctrl dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .rb_n_in(!rb_low), .io_in(io), .pins_out(pins));
	nsq_nand_model #(.MAKER(MAKER), .DEVICE(DEVICE)) dev (.clk_in(sys_clk_in), .pins_in(pins), .fail_in(fail),
		.rb_low_out(rb_low), .io_out(dev_io));
	function automatic logic [7:0] id_exp(input int s, input int i);
		logic [39:0] v;
		v = s ? {32'h4F4E_4649, 8'h00} : {MAKER, DEVICE, 8'h90, 8'h95, 8'h07};
		return v[39 - 8 * i -: 8];
	endfunction
	function automatic logic [7:0] st_exp(input logic wp, input logic f);
		return {wp, 2'b11, 3'b000, f, f};
	endfunction
	task automatic end_of_test();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			failures++;
			end_of_test();
		end
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk_in);
	endtask
	// one link cycle, then poll until the controller is done with it
	task automatic ctl(input nsq_kind_e k, input logic [7:0] b);
		int n;
		n = 0;
		apb(1, REG_CTRL, 32'(b) | (32'(k) << CTRL_KIND_LSB));
		do begin
			apb(0, REG_STAT, 0);
			n++;
		end while (r[STAT_BUSY] !== 1'b0 && n < 50);
		if (r[STAT_BUSY] !== 1'b0) begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic idle_wait();
		int n;
		n = 0;
		do begin
			apb(0, REG_STAT, 0);
			n++;
		end while (r[STAT_GUARD] !== 1'b0 && n < 400);
		if (r[STAT_GUARD] !== 1'b0) begin
			failures++;
			end_of_test();
		end
	endtask
	initial begin
		#300_000;
		failures++;
		end_of_test();
	end
	initial begin
		void'($urandom(62));
		repeat (3) @(posedge sys_clk_in);
		nrst_in <= 1;
		@(posedge sys_clk_in);
		apb(0, REG_CFG, 0);
		chk(r, 0);
		apb(0, 12'h0FC, 0);
		chk({r[30:0], err}, 1);
		for (int s = 0; s < 2; s++) begin
			ctl(K_CMD, CMD_ID);
			ctl(K_ADDR, s ? 8'h20 : 8'h00);
			for (int i = 0; i < 5 - s; i++) begin
				ctl(K_DOUT, 0);
				chk(r[15:8], id_exp(s, i));
			end
		end
		apb(1, REG_CTRL, 32'(CMD_STATUS));
		ctl(K_CMD, CMD_STATUS);
		chk(r[STAT_REFUSED], 1);
		apb(1, REG_STAT, 32'h0000_0004);
		// first pass with write protect held low, second with it released
		for (int w = 0; w < 2; w++) begin
			apb(1, REG_CFG, w);
			for (int c = 0; c < 3; c++) begin
				fb = 1'($urandom);
				fail <= fb;
				ctl(K_CMD, c == 2 ? 8'h60 : CMD_PROG_LOAD);
				repeat (c == 2 ? 3 : 5) ctl(K_ADDR, 8'($urandom));
				if (c != 2) begin
					ctl(K_DIN, 8'($urandom));
					ctl(K_CMD, CMD_RAND_IN);
					repeat (2) ctl(K_ADDR, 8'($urandom % 16));
					ctl(K_DIN, 8'($urandom));
				end
				ctl(K_CMD, conf[c]);
				chk(r[STAT_RB], !w);
				ctl(K_CMD, CMD_ID);
				chk(r[STAT_REFUSED], 1);
				apb(1, REG_STAT, 32'h0000_0004);
				idle_wait();
				chk(r[STAT_REFUSED], 0);
				ctl(K_CMD, CMD_STATUS);
				ctl(K_DOUT, 0);
				chk(r[15:8], st_exp(w, w & fb));
			end
		end
		fail <= 1;
		apb(1, REG_CFG, 32'h0000_0003);
		apb(0, REG_CFG, 32'h0000_0000);
		chk(r, 32'h0000_0003);
		ctl(K_CMD, CMD_PROG_LOAD);
		repeat (5) ctl(K_ADDR, 8'h00);
		ctl(K_CMD, CMD_PROG_CONF);
		ctl(K_CMD, CMD_RESET);
		chk(r[STAT_REFUSED], 0);
		idle_wait();
		ctl(K_CMD, CMD_STATUS);
		ctl(K_DOUT, 0);
		chk(r[15:8], 8'hE0);
		chk(pins.ce_n, 0);
		end_of_test();
	end
endmodule
